//--- verilog/frame_decoder_pkg.sv
/*
 package for the motion command frame decoder: command codes, frame
 lengths, field positions and reset values.
 assumes a byte-level bus slave front end delivers received bytes.
*/
package frame_decoder_pkg;

    localparam logic [1:0] ADDR_TOP_BITS       = 2'h3;
    localparam int         ADDR_TOP_MSB        = 7;
    localparam int         ADDR_TOP_LSB        = 6;
    localparam int         ADDR_NODE_MSB       = 5;
    localparam int         ADDR_NODE_LSB       = 2;
    localparam int         ADDR_PIN_BIT        = 1;
    localparam int         ADDR_RW_BIT         = 0;

    localparam logic [7:0] CMD_FUSE_PROGRAM    = 8'h90;
    localparam logic [7:0] CMD_ABSOLUTE_MOVE   = 8'h8b;
    localparam logic [7:0] CMD_CONTROLLED_HALT = 8'h8f;
    localparam logic [7:0] CMD_EMF_PROBE       = 8'h9f;
    localparam logic [7:0] FILLER_BYTE         = 8'hff;
    localparam logic [4:0] FUSE_SEL_PREFIX     = 5'h1f;

    localparam logic [2:0] LEN_SHORT_FRAME     = 3'h2;
    localparam logic [2:0] LEN_LONG_FRAME      = 3'h6;

    localparam logic [15:0] POSITION_RESET     = 16'h0000;
    localparam logic [7:0]  BYTE_RESET         = 8'h00;
    localparam logic [2:0]  INDEX_RESET        = 3'h0;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic       strobe;
        logic [2:0] select;
        logic [7:0] data;
    } fuse_write_t;

endpackage : frame_decoder_pkg

//--- verilog/sync_bit.sv
/*
 two-flop level synchroniser.
 assumes the input is asynchronous to clock_in.
*/
`timescale 1ns/1ps
module sync_bit (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;

    // first stage is read only by the second
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sync_bit

//--- verilog/motion_command_frame_decoder.sv
/*
 command frame decoder and executor for four positioning commands.
 assumes a bus slave delivers bytes with first/last markers on clock_in,
 and that motion, fuse and analog logic sit outside.
*/
// What this block does
// - address byte 11, node bits, pin bit, 0
// - fuse frame 0x90, two fillers, select, data
// - complete fuse frame writes data to word
// - move frame 0x8b, fillers, position high, low
// - target is signed 16-bit absolute set-point
// - drop move when arbitration says busy
// - overtemperature raises halt without command
// - halt decelerates to minimum velocity, stops
// - at rest, copy actual into target
// - halt frame is address plus 0x8f
// - probe frame is address plus 0x9f
// - probe routes integrator to switch pin
// - probe mode sticks until power-on reset
// - probe mode blocks switch pin sampling
`timescale 1ns/1ps
module motion_command_frame_decoder (
    input  wire logic                         clock_in,
    input  wire logic                         rst_n_in,
    input  wire frame_decoder_pkg::rx_byte_t  rx_byte_in,
    input  wire logic [3:0]                   fused_node_addr_in,
    input  wire logic                         addr_pin_bit_in,
    input  wire logic                         move_blocked_in,
    input  wire logic                         over_temp_in,
    input  wire logic                         motor_at_rest_in,
    input  wire logic [15:0]                  actual_position_in,
    input  wire logic                         switch_input_pin_in,
    output frame_decoder_pkg::fuse_write_t    fuse_write_out,
    output logic [15:0]                       target_position_out,
    output logic                              target_update_out,
    output logic                              halt_request_out,
    output logic                              emf_probe_active_out,
    output logic                              switch_state_out
);
    import frame_decoder_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic        over_temp_sync;
    logic        switch_sync;
    logic [2:0]  index_reg;
    logic        drop_reg;
    logic [7:0]  cmd_reg;
    logic [7:0]  b4_reg;
    logic [15:0] target_position_reg;
    logic        halting_reg;

    sync_bit u_temp_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in (over_temp_in),
        .sync_out (over_temp_sync)
    );

    sync_bit u_switch_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in (switch_input_pin_in),
        .sync_out (switch_sync)
    );

    ////////////////////////////////////////////////////////////////////
    wire rx_valid = rx_byte_in.valid;
    wire rx_first = rx_byte_in.first;
    wire rx_last  = rx_byte_in.last;
    wire [7:0] rx_data = rx_byte_in.data;

    wire addr_ok = rx_data[ADDR_TOP_MSB:ADDR_TOP_LSB] == ADDR_TOP_BITS
        && rx_data[ADDR_NODE_MSB:ADDR_NODE_LSB] == fused_node_addr_in
        && rx_data[ADDR_PIN_BIT] == addr_pin_bit_in
        && !rx_data[ADDR_RW_BIT];

    wire [2:0] pos_now = rx_first ? INDEX_RESET : index_reg;
    wire [2:0] pos_inc = pos_now + 3'h1;
    wire       hdr_bad = rx_first && !addr_ok;
    wire filler_bad = (pos_now == 3'h2 || pos_now == 3'h3)
        && rx_data != FILLER_BYTE;
    wire sel_bad = pos_now == 3'h4 && cmd_reg == CMD_FUSE_PROGRAM
        && rx_data[7:3] != FUSE_SEL_PREFIX;
    wire bad_now = hdr_bad || filler_bad || sel_bad
        || (!rx_first && drop_reg) || (pos_now > 3'h5);
    wire [7:0] cmd_now = pos_now == 3'h1 ? rx_data : cmd_reg;

    wire frame_done = rx_valid && rx_last && !bad_now;
    wire short_done = frame_done && pos_inc == LEN_SHORT_FRAME;
    wire long_done  = frame_done && pos_inc == LEN_LONG_FRAME;

    wire fuse_go  = long_done && cmd_reg == CMD_FUSE_PROGRAM;
    wire move_go  = long_done && cmd_reg == CMD_ABSOLUTE_MOVE
        && !move_blocked_in && !halting_reg;
    wire halt_cmd = short_done && cmd_now == CMD_CONTROLLED_HALT;
    wire probe_go = short_done && cmd_now == CMD_EMF_PROBE;
    wire halt_go  = halt_cmd || over_temp_sync;
    // copy only once motion logic reports rest, so the stop point holds
    wire halt_end = halting_reg && motor_at_rest_in && !halt_go;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            index_reg <= INDEX_RESET;
            drop_reg  <= 1'b0;
            cmd_reg   <= BYTE_RESET;
            b4_reg    <= BYTE_RESET;
        end else if (rx_valid) begin
            index_reg <= rx_last ? INDEX_RESET : pos_inc;
            drop_reg  <= bad_now && !rx_last;
            cmd_reg   <= cmd_now;
            if (pos_now == 3'h4) begin
                b4_reg <= rx_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fuse_write_out <= '0;
        end else begin
            fuse_write_out.strobe <= fuse_go;
            if (fuse_go) begin
                fuse_write_out.select <= b4_reg[2:0];
                fuse_write_out.data   <= rx_data;
            end
        end
    end

    // halt wins over a move arriving in the same cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            target_position_reg <= POSITION_RESET;
            target_update_out   <= 1'b0;
            halting_reg         <= 1'b0;
        end else begin
            target_update_out <= (move_go && !halt_go) || halt_end;
            if (halt_go) begin
                halting_reg <= 1'b1;
            end else if (halt_end) begin
                halting_reg         <= 1'b0;
                target_position_reg <= actual_position_in;
            end else if (move_go) begin
                target_position_reg <= {b4_reg, rx_data};
            end
        end
    end
    assign target_position_out = target_position_reg;
    assign halt_request_out    = halting_reg;

    // sticky on purpose: only the power-on reset leaves probe mode
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            emf_probe_active_out <= 1'b0;
            switch_state_out     <= 1'b0;
        end else begin
            if (probe_go) begin
                emf_probe_active_out <= 1'b1;
            end
            if (!emf_probe_active_out && !probe_go) begin
                switch_state_out <= switch_sync;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    probe_sticky_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        emf_probe_active_out |=> emf_probe_active_out)
        else $error("probe mode left");

    probe_enter_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        probe_go |=> emf_probe_active_out)
        else $error("probe command not taken");

    switch_freeze_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        emf_probe_active_out |=> $stable(switch_state_out))
        else $error("switch sampled in probe mode");

    temp_halt_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        over_temp_sync |=> halt_request_out)
        else $error("overtemperature did not halt");

    halt_copy_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        halt_end |=> target_position_out == $past(actual_position_in)
            && !halt_request_out && target_update_out)
        else $error("stop point not held");

    move_load_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (move_go && !halt_go && !halt_end) |=>
            target_position_out == {$past(b4_reg), $past(rx_data)})
        else $error("target not loaded");

    move_drop_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (long_done && move_blocked_in && !halt_end) |=>
            $stable(target_position_out))
        else $error("blocked move applied");

    fuse_once_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        fuse_write_out.strobe |=> !fuse_write_out.strobe)
        else $error("fuse strobe too long");

    fuse_load_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        fuse_go |=> fuse_write_out.strobe
            && fuse_write_out.select == $past(b4_reg[2:0])
            && fuse_write_out.data == $past(rx_data))
        else $error("fuse word not written");

    halt_cmd_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        halt_cmd |=> halt_request_out)
        else $error("halt command not taken");

    early_end_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (rx_valid && rx_last && !short_done && !long_done
            && !over_temp_sync && !halt_end) |=>
            !fuse_write_out.strobe && !target_update_out
            && $stable(halt_request_out))
        else $error("bad frame acted on");

endmodule : motion_command_frame_decoder

//--- verification/frame_master.sv
/*
 partner model: bus master handing command frames over as a byte stream.
 assumes the decoder samples bytes on the rising edge of clock_in.
*/
`timescale 1ns/1ps
module frame_master (
    input  wire logic                   clock_in,
    output frame_decoder_pkg::rx_byte_t rx_byte_out
);
    import frame_decoder_pkg::*;

    initial rx_byte_out = '0;

    ////////////////////////////////////////////////////////////////////////
    // bytes leave msb first from the top of b; n may stop a frame early
    task automatic send(input logic [2:0] n, input logic [47:0] b);
        for (int i = 0; i < n; i++) begin
            @(posedge clock_in);
            #1;
            rx_byte_out.valid = 1'b1;
            rx_byte_out.first = (i == 0);
            rx_byte_out.last  = (i == n - 1);
            rx_byte_out.data  = b[47 - 8 * i -: 8];
        end
        @(posedge clock_in);
        #1;
        rx_byte_out.valid = 1'b0;
        rx_byte_out.first = 1'b0;
        rx_byte_out.last  = 1'b0;
        // released data must not look like the last byte
        rx_byte_out.data  = ~rx_byte_out.data;
    endtask : send
endmodule : frame_master

//--- verification/motion_command_frame_decoder_tb_top.sv
/*
 bench for the frame decoder: table of frames, then halt, probe, reset.
 assumes frame_master drives the byte stream on the same clock.
*/
`timescale 1ns/1ps
module motion_command_frame_decoder_tb_top;
    import frame_decoder_pkg::*;
    typedef struct packed {
        logic [2:0]  n;
        logic [47:0] b;
        logic        upd;
        logic        stb;
    } row_t;
    localparam logic [7:0] A = 8'hea;
    localparam logic [7:0] F = 8'hff;
    logic        clock_in, rst_n_in, addr_pin_bit_in, move_blocked_in;
    logic        over_temp_in, motor_at_rest_in, switch_input_pin_in;
    logic [3:0]  fused_node_addr_in;
    logic [15:0] actual_position_in, target_position_out, exp_pos;
    logic        target_update_out, halt_request_out;
    logic        emf_probe_active_out, switch_state_out;
    rx_byte_t    rx_byte_in;
    fuse_write_t fuse_write_out;
    wire [10:0]  fuse_seen = {fuse_write_out.select, fuse_write_out.data};
    int          fail_count, total_checks;
    row_t        rows [0:10];

    frame_master u_master (.clock_in, .rx_byte_out(rx_byte_in));
    motion_command_frame_decoder u_dut (.clock_in, .rst_n_in, .rx_byte_in,
        .fused_node_addr_in, .addr_pin_bit_in, .move_blocked_in,
        .over_temp_in, .motor_at_rest_in, .actual_position_in,
        .switch_input_pin_in, .fuse_write_out, .target_position_out,
        .target_update_out, .halt_request_out, .emf_probe_active_out,
        .switch_state_out);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask : tick
    // send returns just after the edge that takes the last byte,
    // so the registered answer is already in view
    task automatic frame(input logic [2:0] n, input logic [47:0] b);
        u_master.send(n, b);
    endtask : frame
    task automatic wrap_up;
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    initial begin
        #150000;
        fail_count++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_in = 1'b0;
        move_blocked_in = 1'b0;
        over_temp_in = 1'b0;
        motor_at_rest_in = 1'b0;
        actual_position_in = 16'h1234;
        switch_input_pin_in = 1'b1;
        fused_node_addr_in = 4'ha;
        addr_pin_bit_in = 1'b1;
        exp_pos = 16'h0000;
        rows[0]='{3'h6,{A,8'h8b,F,F,16'h8001},1'b1,1'b0};
        rows[1]='{3'h6,{A,8'h90,F,F,8'hfd,8'ha5},1'b0,1'b1};
        rows[2]='{3'h6,{A,8'h90,F,F,8'hf8,8'h3c},1'b0,1'b1};
        rows[3]='{3'h6,{A,8'h8b,F,8'hfe,16'h1111},1'b0,1'b0};
        rows[4]='{3'h6,{8'heb,8'h8b,F,F,16'h2222},1'b0,1'b0};
        rows[5]='{3'h6,{8'h6a,8'h8b,F,F,16'h2222},1'b0,1'b0};
        rows[6]='{3'h6,{8'he6,8'h8b,F,F,16'h2222},1'b0,1'b0};
        rows[7]='{3'h6,{A,8'h90,F,F,8'h75,8'h01},1'b0,1'b0};
        rows[8]='{3'h5,{A,8'h8b,F,F,16'h3300},1'b0,1'b0};
        rows[9]='{3'h2,{A,8'h91,32'h0},1'b0,1'b0};
        rows[10]='{3'h6,{A,8'h8b,F,F,16'h7fff},1'b1,1'b0};
        tick(10);
        chk({halt_request_out, emf_probe_active_out, target_update_out},
            16'h0000);
        chk(target_position_out, 16'h0000);
        rst_n_in = 1'b1;
        foreach (rows[k]) begin
            frame(rows[k].n, rows[k].b);
            if (rows[k].upd)
                exp_pos = rows[k].b[15:0];
            chk(target_update_out, rows[k].upd);
            chk(target_position_out, exp_pos);
            chk(fuse_write_out.strobe, rows[k].stb);
            if (rows[k].stb)
                chk(fuse_seen, rows[k].b[10:0]);
            tick(1);
            chk(target_update_out | fuse_write_out.strobe, 1'b0);
        end
        // arbitration busy: the move is dropped
        move_blocked_in = 1'b1;
        frame(3'h6, {A, 8'h8b, F, F, 16'h4444});
        chk(target_update_out, 1'b0);
        chk(target_position_out, exp_pos);
        move_blocked_in = 1'b0;
        frame(3'h2, {A, 8'h8f, 32'h0});
        chk(halt_request_out, 1'b1);
        frame(3'h6, {A, 8'h8b, F, F, 16'h5555});
        chk(target_update_out, 1'b0);
        chk(target_position_out, exp_pos);
        motor_at_rest_in = 1'b1;
        tick(1);
        chk(target_update_out, 1'b1);
        chk(target_position_out, 16'h1234);
        chk(halt_request_out, 1'b0);
        motor_at_rest_in = 1'b0;
        actual_position_in = 16'h0777;
        over_temp_in = 1'b1;
        tick(4);
        chk(halt_request_out, 1'b1);
        over_temp_in = 1'b0;
        motor_at_rest_in = 1'b1;
        for (int i = 0; i < 8 && halt_request_out !== 1'b0; i++) tick(1);
        chk(target_position_out, 16'h0777);
        chk(halt_request_out, 1'b0);
        motor_at_rest_in = 1'b0;
        chk(switch_state_out, 1'b1);
        frame(3'h2, {A, 8'h9f, 32'h0});
        chk(emf_probe_active_out, 1'b1);
        switch_input_pin_in = 1'b0;
        tick(5);
        chk(switch_state_out, 1'b1);
        frame(3'h2, {A, 8'h8f, 32'h0});
        chk(emf_probe_active_out, 1'b1);
        // only a reset may leave probe mode
        rst_n_in = 1'b0;
        tick(2);
        chk(emf_probe_active_out, 1'b0);
        rst_n_in = 1'b1;
        // pin high again so resumed sampling shows after reset
        switch_input_pin_in = 1'b1;
        tick(5);
        chk(switch_state_out, 1'b1);
        wrap_up();
    end
endmodule : motion_command_frame_decoder_tb_top
